// file: fpt_debounce.sv
// Key debouncer: one press pulse per stable closure of each key
`default_nettype none
module fpt_debounce #(
  parameter int DEBOUNCE_CYCLES = fpt_pkg::DEBOUNCE_CYCLES
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Raw keys and debounced presses
  input wire logic [fpt_pkg::NUM_KEYS-1:0] raw,
  output logic [fpt_pkg::NUM_KEYS-1:0] press
);
  typedef struct packed {
    logic [fpt_pkg::NUM_KEYS-1:0] stable;
    logic [fpt_pkg::NUM_KEYS-1:0] press;
    logic [fpt_pkg::NUM_KEYS-1:0][fpt_pkg::DB_CNT_W-1:0] cnt;
  } fpt_db_state_t;

  fpt_db_state_t st_r;
  fpt_db_state_t st_nxt;
  localparam logic [fpt_pkg::DB_CNT_W-1:0] LAST = fpt_pkg::DB_CNT_W'(DEBOUNCE_CYCLES - 1);

  // A change must hold for the whole window before it is believed
  always_comb begin
    st_nxt = st_r;
    st_nxt.press = '0;
    for (int i = 0; i < fpt_pkg::NUM_KEYS; i++) begin
      if (raw[i] == st_r.stable[i]) begin
        st_nxt.cnt[i] = '0;
      end else if (st_r.cnt[i] == LAST) begin
        st_nxt.cnt[i] = '0;
        st_nxt.stable[i] = raw[i];
        st_nxt.press[i] = raw[i];
      end else begin
        st_nxt.cnt[i] = st_r.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign press = st_r.press;
endmodule : fpt_debounce
`default_nettype wire

// file: fpt_front_panel.sv
// Front-panel tuning resolution, digit display, blanking and knob decode with AHB-Lite registers
// Contract
// - 1 kHz key lights all four indicators, knob steps 1 kHz.
// - Second key drops the lowest indicator, knob steps 10 kHz.
// - Third key drops the 10 kHz indicator, knob steps 1 MHz.
// - Top key leaves only the top indicator, knob steps 100 MHz.
// - Hold darkens all indicators and knob no longer tunes.
// - External standard lights external-reference and unlocked annunciators.
// - Remote out-of-range setting lights remote and out-of-range annunciators.
// - Back to local while out of range, tune at 1 kHz unless a key chosen.
// - Resolution serial output rises with the matching digit clock pulse.
// - Lowest-digit resolution line is low while the 1 kHz key is selected.
// - Add-now strobe only while the selected digit is at the adder.
// - Each digit latches into its own display place, 1 kHz digit first; the code latches only the first eight of the nine digits.
// - Display latch uses a delayed digit clock so data settles first.
// - Top four digits blank only while all higher digits are zero.
// - Zero level clocked by undelayed clock; chain resets on the next pulse.
// - Phase A leading phase B means clockwise tuning.
// - Selection loads the serial register when start-data-cycle ends, then shifts.
// - Going remote loads an empty selection, disabling the adder.
//
// The address map and the AHB-Lite register port were left to the implementer.
`default_nettype none
module fpt_front_panel #(
  parameter int DEBOUNCE_CYCLES = fpt_pkg::DEBOUNCE_CYCLES
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Panel, sequencer and knob inputs
  input wire fpt_pkg::fpt_panel_in_t panel,
  input wire fpt_pkg::fpt_digit_in_t digit,
  input wire fpt_pkg::fpt_encoder_t tuning_encoder,
  // Indicators and adder control
  output logic [3:0] resolution_indicator,
  output logic lowest_digit_resolution_n,
  output logic add_now,
  output fpt_pkg::fpt_annun_t annun,
  // Display
  output logic [31:0] display_digits,
  output logic [3:0] display_blank,
  // Tuning steps
  output logic tune_step_up,
  output logic tune_step_down
);
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic tune_en;
    logic res_valid;
    logic [1:0] res_idx;
    logic [3:0] ind;
    logic lsd_n;
    logic add_now;
    logic [8:0] res_shift;
    logic go_d;
    logic dclk_d;
    logic [fpt_pkg::SETTLE_CYCLES:0] dclk_pipe;
    logic cycle_d;
    logic [3:0] dig_idx;
    logic [3:0] zero;
    logic [31:0] disp;
    logic [3:0] blank;
    logic enc_a_d;
    logic step_up;
    logic step_dn;
    logic [15:0] step_cnt;
    logic local_d;
    fpt_pkg::fpt_annun_t annun;
  } fpt_state_t;

  fpt_state_t st_r;
  fpt_state_t st_nxt;
  logic [fpt_pkg::NUM_KEYS-1:0] key_press;
  logic sw_hold;

  // Digit position driven by each resolution key
  function automatic logic [3:0] key_digit(input logic [1:0] idx);
    logic [3:0] d;
    d = fpt_pkg::DIG_1K;
    unique case (idx)
      2'h0: d = fpt_pkg::DIG_1K;
      2'h1: d = fpt_pkg::DIG_10K;
      2'h2: d = fpt_pkg::DIG_1M;
      2'h3: d = fpt_pkg::DIG_100M;
    endcase
    return d;
  endfunction : key_digit

  // Chosen indicator plus every more significant one
  function automatic logic [3:0] ind_mask(input logic valid, input logic [1:0] idx);
    logic [3:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i] = valid && (2'(i) >= idx);
    end
    return m;
  endfunction : ind_mask

  // Leading-zero chain from the most significant digit down
  function automatic logic [3:0] blank_chain(input logic [3:0] z);
    logic [3:0] b;
    b = '0;
    b[3] = z[3];
    for (int k = 2; k >= 0; k--) begin
      b[k] = z[k] && b[k + 1];
    end
    return b;
  endfunction : blank_chain

  // Register read view
  function automatic logic [31:0] read_mux(input fpt_state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    unique case (a)
      fpt_pkg::REG_CTRL: r[fpt_pkg::CTRL_TUNE_EN] = s.tune_en;
      fpt_pkg::REG_STATUS: r = {16'h0000, s.annun, s.blank, s.ind, s.res_valid, 1'b0, s.res_idx};
      fpt_pkg::REG_DISPLAY: r = s.disp;
      fpt_pkg::REG_STEPS: r = {16'h0000, s.step_cnt};
      default: r = '0;
    endcase
    return r;
  endfunction : read_mux

  fpt_debounce #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) i_fpt_debounce (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .raw({panel.hold_key, panel.res_key}),
    .press(key_press)
  );

  // Software hold is a write of one to the hold bit
  assign sw_hold = st_r.wr_pend && (st_r.wr_addr == fpt_pkg::REG_CTRL) && hwdata[fpt_pkg::CTRL_HOLD];

  always_comb begin
    logic dclk_rise;
    logic dclk_fall;
    logic late_rise;
    logic addr_ok;
    logic tuning;
    dclk_rise = 1'b0;
    dclk_fall = 1'b0;
    late_rise = 1'b0;
    addr_ok = 1'b0;
    tuning = 1'b0;
    st_nxt = st_r;

    // Bus: zero-wait slave, read data prepared in the address phase
    st_nxt.hreadyout = 1'b1;
    st_nxt.hresp = 1'b0;
    addr_ok = hsel && htrans[1] && hready;
    st_nxt.wr_pend = addr_ok && hwrite;
    if (addr_ok) begin
      st_nxt.wr_addr = haddr;
      st_nxt.hrdata = read_mux(st_r, haddr);
    end
    if (st_r.wr_pend && (st_r.wr_addr == fpt_pkg::REG_CTRL)) begin
      st_nxt.tune_en = hwdata[fpt_pkg::CTRL_TUNE_EN];
    end

    // Resolution keys; the lowest pressed key wins a tie
    // key selection
    for (int i = 3; i >= 0; i--) begin
      if (key_press[i]) begin
        st_nxt.res_valid = 1'b1;
        st_nxt.res_idx = 2'(i);
      end
    end
    if (key_press[fpt_pkg::HOLD_KEY] || sw_hold) begin
      st_nxt.res_valid = 1'b0;
    end
    st_nxt.local_d = panel.local_mode;
    if (st_r.local_d && !panel.local_mode) begin
      st_nxt.res_valid = 1'b0;
    end
    if (!st_r.local_d && panel.local_mode && panel.error_store_flag && !(|key_press[3:0])) begin
      st_nxt.res_valid = 1'b1;
      st_nxt.res_idx = fpt_pkg::RES_1K;
    end

    st_nxt.ind = ind_mask(st_nxt.res_valid, st_nxt.res_idx);
    st_nxt.lsd_n = !(st_nxt.res_valid && (st_nxt.res_idx == fpt_pkg::RES_1K));

    // Annunciators follow their sources
    // external reference lamps
    st_nxt.annun.external_reference_annunciator = panel.external_reference_annunciator_sel;
    st_nxt.annun.phase_unlocked = panel.external_reference_annunciator_sel || panel.phase_unlocked;
    st_nxt.annun.remote = !panel.local_mode;
    st_nxt.annun.out_of_range_annunciator = panel.error_store_flag;

    // Edges of the sequencer lines
    st_nxt.dclk_d = digit.digit_clock;
    st_nxt.go_d = digit.start_data_cycle;
    st_nxt.cycle_d = digit.cycle;
    dclk_rise = digit.digit_clock && !st_r.dclk_d;
    dclk_fall = !digit.digit_clock && st_r.dclk_d;

    if (st_r.go_d && !digit.start_data_cycle) begin
      st_nxt.res_shift = st_r.res_valid ? (9'h001 << key_digit(st_r.res_idx)) : 9'h000;
    end else if (dclk_fall) begin
      st_nxt.res_shift = st_r.res_shift >> 1;
    end
    st_nxt.add_now = digit.digit_clock && st_r.res_shift[0] && !digit.cycle;

    // delayed latch clock, settles data lines
    st_nxt.dclk_pipe = {st_r.dclk_pipe[fpt_pkg::SETTLE_CYCLES-1:0], digit.digit_clock};
    late_rise = st_r.dclk_pipe[fpt_pkg::SETTLE_CYCLES-1] && !st_r.dclk_pipe[fpt_pkg::SETTLE_CYCLES];

    // digit index from the 1 kHz digit
    if (digit.cycle) begin
      st_nxt.dig_idx = '0;
    end else if (late_rise && (st_r.dig_idx < fpt_pkg::NUM_DIGITS)) begin
      if (st_r.dig_idx < fpt_pkg::NUM_SHOWN) begin
        st_nxt.disp[st_r.dig_idx[2:0] * 4 +: 4] = digit.digit_data_lines;
      end
      st_nxt.dig_idx = st_r.dig_idx + 1'b1;
    end

    if (dclk_rise && !digit.cycle) begin
      if (st_r.dig_idx == '0) begin
        st_nxt.zero = '0;
      end else if ((st_r.dig_idx >= fpt_pkg::FIRST_BLANKABLE) && (st_r.dig_idx < fpt_pkg::NUM_SHOWN)) begin
        st_nxt.zero[st_r.dig_idx[1:0]] = (digit.digit_data_lines == fpt_pkg::BCD_ZERO);
      end
    end
    // chain settles when the half-cycle ends
    if (digit.cycle && !st_r.cycle_d) begin
      st_nxt.blank = blank_chain(st_r.zero);
    end

    st_nxt.enc_a_d = tuning_encoder.encoder_phase_a;
    tuning = st_r.res_valid && st_r.tune_en && tuning_encoder.encoder_phase_a && !st_r.enc_a_d;
    st_nxt.step_up = tuning && !tuning_encoder.encoder_phase_b;
    st_nxt.step_dn = tuning && tuning_encoder.encoder_phase_b;
    // Net step count wraps; software reads differences
    if (st_nxt.step_up) begin
      st_nxt.step_cnt = st_r.step_cnt + 1'b1;
    end else if (st_nxt.step_dn) begin
      st_nxt.step_cnt = st_r.step_cnt - 1'b1;
    end
  end

  // Power-up: no resolution, tuning disabled until a key is pressed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.hreadyout <= 1'b1;
      st_r.lsd_n <= 1'b1;
      st_r.tune_en <= fpt_pkg::CTRL_TUNE_EN_RST;
      st_r.local_d <= 1'b1;
      st_r.cycle_d <= 1'b1; // Cycle line idles high: no false half-cycle edge after reset
      st_r.annun <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign hrdata = st_r.hrdata;
  assign hreadyout = st_r.hreadyout;
  assign hresp = st_r.hresp;
  assign resolution_indicator = st_r.ind;
  assign lowest_digit_resolution_n = st_r.lsd_n;
  assign add_now = st_r.add_now;
  assign annun = st_r.annun;
  assign display_digits = st_r.disp;
  assign display_blank = st_r.blank;
  assign tune_step_up = st_r.step_up;
  assign tune_step_down = st_r.step_dn;
endmodule : fpt_front_panel
`default_nettype wire

// file: fpt_front_panel_assertions.sv
// Checker of the panel block's port relations
`default_nettype none
module fpt_front_panel_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Inputs watched
  input wire fpt_pkg::fpt_panel_in_t panel,
  input wire fpt_pkg::fpt_digit_in_t digit,
  input wire fpt_pkg::fpt_encoder_t tuning_encoder,
  // Outputs watched
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [3:0] resolution_indicator,
  input wire logic lowest_digit_resolution_n,
  input wire logic add_now,
  input wire fpt_pkg::fpt_annun_t annun,
  input wire logic [3:0] display_blank,
  input wire logic tune_step_up,
  input wire logic tune_step_down
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  lsd_line_a: assert property (lowest_digit_resolution_n == (resolution_indicator != 4'hf))
    else $error("lowest digit line disagrees with lamps");
  lamp_shape_a: assert property (resolution_indicator inside {4'h0, 4'h8, 4'hc, 4'he, 4'hf})
    else $error("resolution lamps in an illegal pattern");
  add_gate_a: assert property (add_now |-> $past(digit.digit_clock) && !$past(digit.cycle) && resolution_indicator[3])
    else $error("adder strobe outside a selected pulse");
  remote_lamp_a: assert property ($past(ce) |-> annun.remote == !$past(panel.local_mode))
    else $error("remote lamp does not follow mode");
  ref_lamps_a: assert property ($past(ce) |-> annun.phase_unlocked == $past(panel.external_reference_annunciator_sel | panel.phase_unlocked) && annun.out_of_range_annunciator == $past(panel.error_store_flag))
    else $error("reference or range lamp wrong");
  step_dir_a: assert property (tune_step_up || tune_step_down |-> tune_step_up != tune_step_down && tune_step_down == $past(tuning_encoder.encoder_phase_b))
    else $error("tuning step direction wrong");
  hold_dark_a: assert property (resolution_indicator == 4'h0 && $past(resolution_indicator) == 4'h0 |-> !tune_step_up && !tune_step_down)
    else $error("tuning step with no resolution");
  blank_chain_a: assert property (display_blank[2:0] == (display_blank[2:0] & display_blank[3:1]))
    else $error("digit blanked below a shown digit");
  // Slave always ready with OKAY
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
endmodule : fpt_front_panel_assertions
bind fpt_front_panel fpt_front_panel_assertions i_fpt_front_panel_assertions (.hclk(hclk),
  .hresetn(hresetn), .ce(ce), .panel(panel), .digit(digit), .tuning_encoder(tuning_encoder),
  .hreadyout(hreadyout), .hresp(hresp), .resolution_indicator(resolution_indicator),
  .lowest_digit_resolution_n(lowest_digit_resolution_n), .add_now(add_now), .annun(annun),
  .display_blank(display_blank), .tune_step_up(tune_step_up), .tune_step_down(tune_step_down));
`default_nettype wire

// file: fpt_pkg.sv
// Shared constants, register map and carrier types of the front-panel tuning block
`default_nettype none
package fpt_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int DEBOUNCE_NS = 5000000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_NS / CLK_PERIOD_NS;
  localparam int SETTLE_NS = 100;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DB_CNT_W = 17;
  localparam int NUM_KEYS = 5;
  localparam int HOLD_KEY = 4;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DISPLAY = 8'h08;
  localparam logic [7:0] REG_STEPS = 8'h0c;

  // Control fields and reset value
  localparam int CTRL_TUNE_EN = 0;
  localparam int CTRL_HOLD = 1;
  localparam logic CTRL_TUNE_EN_RST = 1'b1;

  // Digit positions, counted from the 1 kHz digit
  localparam logic [3:0] DIG_1K = 4'h0;
  localparam logic [3:0] DIG_10K = 4'h1;
  localparam logic [3:0] DIG_1M = 4'h3;
  localparam logic [3:0] DIG_100M = 4'h5;
  localparam logic [3:0] NUM_DIGITS = 4'h9;
  localparam logic [3:0] NUM_SHOWN = 4'h8;
  localparam logic [3:0] FIRST_BLANKABLE = 4'h4;
  localparam logic [3:0] BCD_ZERO = 4'h0;

  // Key index of the 1 kHz resolution
  localparam logic [1:0] RES_1K = 2'h0;

  // Panel inputs from keys, rear switch and sequencer flags
  typedef struct packed {
    logic [3:0] res_key;
    logic hold_key;
    logic external_reference_annunciator_sel;
    logic phase_unlocked;
    logic local_mode;
    logic error_store_flag;
  } fpt_panel_in_t;

  // Serial digit stream from the sequencer
  typedef struct packed {
    logic digit_clock;
    logic start_data_cycle;
    logic cycle;
    logic [3:0] digit_data_lines;
  } fpt_digit_in_t;

  // Tuning knob phases
  typedef struct packed {
    logic encoder_phase_a;
    logic encoder_phase_b;
  } fpt_encoder_t;

  // Annunciator drives
  typedef struct packed {
    logic remote;
    logic external_reference_annunciator;
    logic phase_unlocked;
    logic out_of_range_annunciator;
  } fpt_annun_t;
endpackage : fpt_pkg
`default_nettype wire

// file: fpt_seq_model.sv
// Sequencer model that feeds serial digit cycles to the panel block
`default_nettype none
module fpt_seq_model (
  // Clock
  input wire logic hclk,
  // Digit stream, adder strobe and its capture
  output fpt_pkg::fpt_digit_in_t digit,
  input wire logic add_now,
  output logic [8:0] hit
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle: second half of a cycle, digit clock still
  initial begin
    digit = '0;
    digit.cycle = 1'b1;
    hit = 9'h0;
  end
  task run(input logic [35:0] d);
    hit = 9'h0;
    digit.start_data_cycle <= 1'b1;
    @(posedge hclk);
    digit.start_data_cycle <= 1'b0;
    digit.cycle <= 1'b0;
    // nine pulses, one BCD digit each
    for (int k = 0; k < 9; k++) begin
      @(posedge hclk);
      digit.digit_data_lines <= d[4*k+:4];
      @(posedge hclk);
      digit.digit_clock <= 1'b1;
      @(posedge hclk);
      digit.digit_clock <= 1'b0;
      @(posedge hclk);
      hit[k] = add_now;
      repeat (2) @(posedge hclk);
      // Released lines show a changed value, not the old digit
      digit.digit_data_lines <= ~d[4*k+:4];
    end
    @(posedge hclk);
    digit.cycle <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask : run
endmodule : fpt_seq_model
`default_nettype wire

// file: tb_fpt_front_panel.sv
// Self-checking bench of the panel block with a sequencer model
`default_nettype none
module tb_fpt_front_panel;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic lowest_digit_resolution_n, add_now, tune_step_up, tune_step_down;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd, display_digits;
  logic [3:0] resolution_indicator, display_blank;
  logic [8:0] hit;
  logic [35:0] d;
  logic [15:0] exp_steps;
  fpt_pkg::fpt_panel_in_t panel;
  fpt_pkg::fpt_digit_in_t digit;
  fpt_pkg::fpt_encoder_t enc;
  fpt_pkg::fpt_annun_t annun;
  int num_errors, n_tests, seed, k, n, z;
  // Clock; the one slave's ready is the bus ready
  always #25 hclk = ~hclk;
  assign hready = hreadyout;
  // Short debounce keeps key presses quick
  fpt_front_panel #(.DEBOUNCE_CYCLES(4)) i_fpt_front_panel (.hclk(hclk), .hresetn(hresetn),
    .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .panel(panel), .digit(digit), .tuning_encoder(enc),
    .resolution_indicator(resolution_indicator),
    .lowest_digit_resolution_n(lowest_digit_resolution_n), .add_now(add_now), .annun(annun),
    .display_digits(display_digits), .display_blank(display_blank),
    .tune_step_up(tune_step_up), .tune_step_down(tune_step_down));
  fpt_seq_model i_fpt_seq_model (.hclk(hclk), .digit(digit), .add_now(add_now), .hit(hit));
  task give_verdict;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Bounded wait for ready at a rising edge
  task rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 20) begin
        num_errors++;
        give_verdict;
      end
      @(posedge hclk);
    end
  endtask : rdy
  // Single word transfer; read data lands in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy;
    rd = hrdata;
  endtask : bus
  // Key held past the debounce count, then let go
  task press(input int key);
    if (key < 4) panel.res_key[key] <= 1'b1;
    else panel.hold_key <= 1'b1;
    repeat (8) @(posedge hclk);
    panel.res_key <= 4'h0;
    panel.hold_key <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask : press
  // one knob detent, phase order sets direction
  task turn(input logic cw);
    logic [7:0] p;
    p = cw ? 8'hb4 : 8'h78;
    for (int i = 3; i >= 0; i--) begin
      enc <= p[2*i+:2];
      repeat (3) @(posedge hclk);
    end
  endtask : turn
  function automatic logic [3:0] blank_of(input logic [31:0] v);
    logic [3:0] b;
    b[3] = v[31:28] == 4'h0;
    for (int j = 2; j >= 0; j--) b[j] = v[16+4*j+:4] == 4'h0 && b[j+1];
    return b;
  endfunction : blank_of
  function automatic logic [3:0] pos_of(input int key);
    case (key)
      0: return fpt_pkg::DIG_1K;
      1: return fpt_pkg::DIG_10K;
      2: return fpt_pkg::DIG_1M;
      default: return fpt_pkg::DIG_100M;
    endcase
  endfunction : pos_of
  // Main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    ce = 1'b1;
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    panel = '0;
    panel.local_mode = 1'b1;
    enc = '0;
    {num_errors, n_tests, exp_steps} = '0;
    seed = 32'h7cb7;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("indicators", 36'h0, resolution_indicator);
    bus(1'b0, fpt_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 36'h1, rd);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 36'h0, rd);
    bus(1'b1, fpt_pkg::REG_CTRL, 32'h1);
    turn(1'b1);
    for (k = 0; k < 4; k++) begin
      press(k);
      chk("indicators", 4'(4'hf << k), resolution_indicator);
      chk("lsd line", k != 0, lowest_digit_resolution_n);
      n = {$random(seed)} % 3 + 1;
      repeat (n) turn(1'b1);
      turn(1'b0);
      exp_steps = exp_steps + 16'(n) - 16'h1;
      bus(1'b0, fpt_pkg::REG_STEPS, 32'h0);
      chk("steps", exp_steps, rd[15:0]);
      for (int j = 0; j < 9; j++) d[4*j+:4] = 4'({$random(seed)} % 10);
      z = {$random(seed)} % 5;
      for (int j = 8 - z; j < 8; j++) d[4*j+:4] = 4'h0;
      i_fpt_seq_model.run(d);
      chk("adder strobe", 9'h1 << pos_of(k), hit);
      chk("display", d[31:0], display_digits);
      chk("blanking", blank_of(d[31:0]), display_blank);
    end
    press(4);
    chk("indicators", 36'h0, resolution_indicator);
    turn(1'b1);
    bus(1'b0, fpt_pkg::REG_STEPS, 32'h0);
    chk("steps", exp_steps, rd[15:0]);
    i_fpt_seq_model.run(d);
    chk("adder strobe", 36'h0, hit);
    // a short bounce is no press
    panel.res_key[3] <= 1'b1;
    repeat (2) @(posedge hclk);
    panel.res_key[3] <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("indicators", 36'h0, resolution_indicator);
    press(2);
    panel.local_mode <= 1'b0;
    panel.external_reference_annunciator_sel <= 1'b1;
    // flag raised for a held out-of-range value
    panel.error_store_flag <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("annunciators", 36'hf, annun);
    chk("indicators", 36'h0, resolution_indicator);
    panel.local_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("indicators", 36'hf, resolution_indicator);
    press(3);
    chk("indicators", 36'h8, resolution_indicator);
    bus(1'b0, fpt_pkg::REG_STATUS, 32'h0);
    chk("status", {16'h0, 4'h7, blank_of(d[31:0]), 4'h8, 4'hb}, rd);
    bus(1'b0, fpt_pkg::REG_DISPLAY, 32'h0);
    chk("display reg", d[31:0], rd);
    // Tuning disabled by software leaves the count alone
    bus(1'b1, fpt_pkg::REG_CTRL, 32'h0);
    turn(1'b1);
    bus(1'b0, fpt_pkg::REG_STEPS, 32'h0);
    chk("steps", exp_steps, rd[15:0]);
    bus(1'b1, fpt_pkg::REG_CTRL, 32'h3);
    repeat (2) @(posedge hclk);
    chk("indicators", 36'h0, resolution_indicator);
    bus(1'b0, fpt_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 36'h1, rd);
    give_verdict;
  end
endmodule : tb_fpt_front_panel
`default_nettype wire
